// File: common/csch_pkg.sv
// Shared constants and types for the channel service scheduler
package csch_pkg;

	// Channel count and width of a channel number
	localparam int CSCH_NUM_CH = 16;
	localparam int CSCH_CH_W = 4;

	// Length of the repeating slot sequence and width of its position
	localparam int CSCH_SEQ_LEN = 7;
	localparam int CSCH_POS_W = 3;
	localparam logic [2:0] CSCH_POS_FIRST = 3'h0;
	localparam logic [2:0] CSCH_POS_LAST = 3'h6;

	// Fixed delays in CPU clocks (the CPU clock is clk_sys)
	localparam int CSCH_TRANS_CLK = 10;
	localparam int CSCH_NOP_CLK = 4;
	localparam int CSCH_CNT_W = 4;

	// Priority level of a channel; off keeps a channel out of arbitration
	typedef enum logic [1:0] {
		CSCH_LVL_OFF = 2'h0,
		CSCH_LVL_LOW = 2'h1,
		CSCH_LVL_MID = 2'h2,
		CSCH_LVL_HIGH = 2'h3
	} csch_level_t;

	// Slot order: high, middle, high, low, high, middle, high
	localparam csch_level_t CSCH_SLOT_SEQ [0:CSCH_SEQ_LEN-1] = '{
		CSCH_LVL_HIGH, CSCH_LVL_MID, CSCH_LVL_HIGH, CSCH_LVL_LOW,
		CSCH_LVL_HIGH, CSCH_LVL_MID, CSCH_LVL_HIGH
	};

	// Scheduler states, one-hot
	typedef enum logic [3:0] {
		CSCH_WAIT = 4'h1,
		CSCH_EXEC = 4'h2,
		CSCH_NOP = 4'h4,
		CSCH_TRANS = 4'h8
	} csch_state_t;

	// Grant handed to the execution unit
	typedef struct packed {
		logic start;
		logic [CSCH_CH_W-1:0] chan;
		csch_level_t level;
	} csch_grant_t;

endpackage

// File: design/csch_scheduler.sv
// Channel service scheduler: picks which channel owns the shared execution unit
`timescale 1ns/1ps
`default_nettype none

module csch_scheduler
	import csch_pkg::*;
#(
	parameter int NUM_CH = CSCH_NUM_CH,
	parameter int TRANS_CLK = CSCH_TRANS_CLK,
	parameter int NOP_CLK = CSCH_NOP_CLK
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [NUM_CH-1:0] chan_req,
	input wire csch_level_t [NUM_CH-1:0] chan_level,
	input wire logic exec_done,
	output csch_grant_t grant,
	output logic [CSCH_POS_W-1:0] slot_pos,
	output logic [NUM_CH-1:0] service_request_latch,
	output logic [NUM_CH-1:0] service_grant_latch,
	output logic exec_busy,
	output logic nop_active,
	output logic trans_active
);

	// Counts are loaded into a narrow counter, so size them once here
	localparam logic [CSCH_CNT_W-1:0] TRANS_LOAD = CSCH_CNT_W'(TRANS_CLK);
	localparam logic [CSCH_CNT_W-1:0] NOP_LOAD = CSCH_CNT_W'(NOP_CLK);
	localparam logic [CSCH_CNT_W-1:0] CNT_LAST = CSCH_CNT_W'(1);
	localparam int TRANS_CHECK = TRANS_CLK;

	// Scheduler state and delay counter
	csch_state_t state;
	logic [CSCH_CNT_W-1:0] dly_cnt;
	// Level of the channel now executing
	csch_level_t srv_lvl;

	// Per-channel eligibility and level membership
	logic [NUM_CH-1:0] elig;
	logic [NUM_CH-1:0] in_high;
	logic [NUM_CH-1:0] in_mid;
	logic [NUM_CH-1:0] in_low;
	logic [NUM_CH-1:0] in_srv;
	logic [NUM_CH-1:0] active_ch;

	// Arbitration results, all combinational in the deciding cycle
	csch_level_t slot_lvl;
	csch_level_t pick_lvl;
	logic [NUM_CH-1:0] pick_vec;
	logic [CSCH_CH_W-1:0] pick_ch;
	logic [NUM_CH-1:0] pick_onehot;
	logic any_high;
	logic any_mid;
	logic any_low;
	logic take_grant;
	logic end_of_state;
	logic group_clr;
	logic [NUM_CH-1:0] clr_mask;
	logic [NUM_CH-1:0] grant_mask;

	// Lowest set bit wins
	function automatic logic [CSCH_CH_W-1:0] lowest_set(input logic [NUM_CH-1:0] vec);
		logic [CSCH_CH_W-1:0] idx;
		idx = '0;
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (vec[i]) begin
				idx = CSCH_CH_W'(i);
			end
		end
		return idx;
	endfunction

	// Per-channel membership and eligibility
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CH; gi++) begin : g_chan
			// Level off means the channel is not part of arbitration
			assign active_ch[gi] = (chan_level[gi] != CSCH_LVL_OFF);
			assign in_high[gi] = (chan_level[gi] == CSCH_LVL_HIGH);
			assign in_mid[gi] = (chan_level[gi] == CSCH_LVL_MID);
			assign in_low[gi] = (chan_level[gi] == CSCH_LVL_LOW);
			assign in_srv[gi] = (chan_level[gi] == srv_lvl);
			// Pending and not yet served in this level's cycle
			assign elig[gi] = service_request_latch[gi] & ~service_grant_latch[gi] & active_ch[gi];
			// Only the picked channel of a taken grant
			assign grant_mask[gi] = take_grant & pick_onehot[gi];
			// Whole level group of the channel just served
			assign clr_mask[gi] = group_clr & in_srv[gi];
		end
	endgenerate

	// Pending summary per level
	assign any_high = |(elig & in_high);
	assign any_mid = |(elig & in_mid);
	assign any_low = |(elig & in_low);

	// Level owning the current slot
	assign slot_lvl = CSCH_SLOT_SEQ[slot_pos];

	// Priority passing, pure logic so it costs no clock cycles
	always_comb begin
		pick_lvl = CSCH_LVL_OFF;
		case (slot_lvl)
			// High slot: high, then middle, then low
			CSCH_LVL_HIGH: begin
				if (any_high) begin
					pick_lvl = CSCH_LVL_HIGH;
				end else if (any_mid) begin
					pick_lvl = CSCH_LVL_MID;
				end else if (any_low) begin
					pick_lvl = CSCH_LVL_LOW;
				end
			end
			// Middle slot: middle, then high, then low
			CSCH_LVL_MID: begin
				if (any_mid) begin
					pick_lvl = CSCH_LVL_MID;
				end else if (any_high) begin
					pick_lvl = CSCH_LVL_HIGH;
				end else if (any_low) begin
					pick_lvl = CSCH_LVL_LOW;
				end
			end
			// Low slot: low, then high, then middle
			CSCH_LVL_LOW: begin
				if (any_low) begin
					pick_lvl = CSCH_LVL_LOW;
				end else if (any_high) begin
					pick_lvl = CSCH_LVL_HIGH;
				end else if (any_mid) begin
					pick_lvl = CSCH_LVL_MID;
				end
			end
			// Sequence table never holds off
			default: begin
				pick_lvl = CSCH_LVL_OFF;
			end
		endcase
	end

	// Candidates of the chosen level
	always_comb begin
		case (pick_lvl)
			CSCH_LVL_HIGH: pick_vec = elig & in_high;
			CSCH_LVL_MID: pick_vec = elig & in_mid;
			CSCH_LVL_LOW: pick_vec = elig & in_low;
			default: pick_vec = '0;
		endcase
	end

	// Lowest channel number first within the level
	assign pick_ch = lowest_set(pick_vec);
	assign pick_onehot = pick_vec & ~(pick_vec - NUM_CH'(1));

	// Grant only when waiting or in the last transition cycle; idle holds the slot
	assign take_grant = (pick_lvl != CSCH_LVL_OFF) &&
		((state == CSCH_WAIT) || ((state == CSCH_TRANS) && (dly_cnt == CNT_LAST)));

	// End of the executing state, seen only while a grant is out
	assign end_of_state = (state == CSCH_EXEC) && exec_done;

	// Group clear when nobody of the served level is still eligible
	assign group_clr = end_of_state && !(|(elig & in_srv));

	// Request latches: a new request beats the clear from a grant
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			service_request_latch <= '0;
		end else begin
			service_request_latch <= (service_request_latch & ~grant_mask) | chan_req;
		end
	end

	// Grant latches: set one at a time, cleared only as a level group
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			service_grant_latch <= '0;
		end else begin
			// Grant and clear never meet: grants happen outside the execute state
			service_grant_latch <= (service_grant_latch & ~clr_mask) | grant_mask;
		end
	end

	// Main sequencing: wait, execute, optional no-op, transition
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state <= CSCH_WAIT;
			dly_cnt <= '0;
		end else begin
			case (state)
				// Idle on the current slot until something is eligible
				CSCH_WAIT: begin
					if (take_grant) begin
						state <= CSCH_EXEC;
					end
				end
				// Slot lasts as long as the state takes
				CSCH_EXEC: begin
					if (end_of_state && group_clr) begin
						state <= CSCH_NOP;
						dly_cnt <= NOP_LOAD;
					end else if (end_of_state) begin
						state <= CSCH_TRANS;
						dly_cnt <= TRANS_LOAD;
					end
				end
				// No-op while the level group is cleared, then transition
				CSCH_NOP: begin
					if (dly_cnt == CNT_LAST) begin
						state <= CSCH_TRANS;
						dly_cnt <= TRANS_LOAD;
					end else begin
						dly_cnt <= dly_cnt - CNT_LAST;
					end
				end
				// Transition; the next grant is decided in its last cycle
				CSCH_TRANS: begin
					if (dly_cnt == CNT_LAST) begin
						state <= take_grant ? CSCH_EXEC : CSCH_WAIT;
						dly_cnt <= '0;
					end else begin
						dly_cnt <= dly_cnt - CNT_LAST;
					end
				end
				default: begin
					state <= CSCH_WAIT;
					dly_cnt <= '0;
				end
			endcase
		end
	end

	// Sequence position moves on only at the end of an executed state
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			slot_pos <= CSCH_POS_FIRST;
		end else if (end_of_state) begin
			// Wrap straight back so the sequence repeats without a gap
			slot_pos <= (slot_pos == CSCH_POS_LAST) ? CSCH_POS_FIRST : slot_pos + CSCH_POS_W'(1);
		end
	end

	// Registered grant handed to the execution unit
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			grant <= '0;
			srv_lvl <= CSCH_LVL_OFF;
		end else begin
			grant.start <= take_grant;
			if (take_grant) begin
				grant.chan <= pick_ch;
				grant.level <= pick_lvl;
				srv_lvl <= pick_lvl;
			end
		end
	end

	// Status levels decoded from the one-hot state
	assign exec_busy = (state == CSCH_EXEC);
	assign nop_active = (state == CSCH_NOP);
	assign trans_active = (state == CSCH_TRANS);

	// Helper: cycles spent in the current transition
	logic [CSCH_CNT_W:0] h_trans;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			h_trans <= '0;
		end else if (state == CSCH_TRANS) begin
			h_trans <= h_trans + (CSCH_CNT_W+1)'(1);
		end else if (state != CSCH_WAIT) begin
			h_trans <= '0;
		end
	end

	// A grant only issues from waiting or from the end of a transition
	AST_SINGLE_UNIT: assert property (@(posedge clk_sys) disable iff (rst)
		grant.start |-> ($past(state) == CSCH_WAIT || $past(state) == CSCH_TRANS) && state == CSCH_EXEC)
		else $error("grant issued while the execution unit was busy");

	// Transition lasts exactly ten clocks
	AST_TRANS_TEN: assert property (@(posedge clk_sys) disable iff (rst)
		(state != CSCH_TRANS && $past(state) == CSCH_TRANS) |-> h_trans == TRANS_CHECK)
		else $error("slot transition length wrong");

	// Group clear gives four no-op clocks then a transition
	AST_NOP_FOUR: assert property (@(posedge clk_sys) disable iff (rst)
		(end_of_state && group_clr) |=> (state == CSCH_NOP)[*4] ##1 (state == CSCH_TRANS))
		else $error("no-op period not four clocks");

	// Granted channel has its grant latch set and request cleared
	AST_GRANT_LATCH: assert property (@(posedge clk_sys) disable iff (rst)
		take_grant && !chan_req[pick_ch] |=> service_grant_latch[grant.chan] && !service_request_latch[grant.chan])
		else $error("latches wrong after grant");

	// High slot with no high request passes to middle
	AST_PASS_HIGH_MID: assert property (@(posedge clk_sys) disable iff (rst)
		(take_grant && slot_lvl == CSCH_LVL_HIGH && !any_high && any_mid) |=> grant.level == CSCH_LVL_MID)
		else $error("high slot did not pass to middle");

	// Low slot with no low request passes to high first
	AST_PASS_LOW_HIGH: assert property (@(posedge clk_sys) disable iff (rst)
		(take_grant && slot_lvl == CSCH_LVL_LOW && !any_low && any_high) |=> grant.level == CSCH_LVL_HIGH)
		else $error("low slot did not pass to high");

	// Idle scheduler stays on its slot
	AST_IDLE_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
		(state == CSCH_WAIT && !take_grant) |=> $stable(slot_pos) && state == CSCH_WAIT)
		else $error("slot moved while idle");

	// Sequence wraps from the last slot to the first
	AST_SEQ_WRAP: assert property (@(posedge clk_sys) disable iff (rst)
		(end_of_state && slot_pos == CSCH_POS_LAST) |=> slot_pos == CSCH_POS_FIRST)
		else $error("sequence did not wrap");

	// Group clear empties every grant latch of the served level
	AST_GROUP_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
		group_clr |=> (service_grant_latch & $past(in_srv)) == '0)
		else $error("level group not cleared");

	// No clear while a peer of the served level is still eligible
	AST_NO_EARLY_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
		(end_of_state && (|(elig & in_srv))) |=> state == CSCH_TRANS && $stable(service_grant_latch))
		else $error("group cleared with a peer pending");

endmodule

`default_nettype wire

// File: testbench/csch_exec_model.sv
// Execution unit model: runs each granted state and reports its end
`timescale 1ns/1ps
`default_nettype none
module csch_exec_model
	import csch_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire csch_grant_t grant,
	input wire logic [3:0] exec_len,
	input wire logic stray,
	output logic exec_done
);
	// Cycles left in the running state
	logic [3:0] cnt;

	// State length follows the granted work, not a fixed slot
	always_ff @(posedge clk_sys) begin
		if (rst)
			cnt <= 4'h0;
		else if (grant.start)
			cnt <= exec_len;
		else if (cnt != 4'h0)
			cnt <= cnt - 4'h1;
	end

	// End pulse; stray pulses at any time, inside or outside a state, are commanded by the bench
	assign exec_done = (cnt == 4'h1) | stray;
endmodule
`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench for the channel service scheduler
`timescale 1ns/1ps
`default_nettype none
module tb
	import csch_pkg::*;
;
	logic clk_sys = 1'h0, rst = 1'h1, stray = 1'h0;
	logic [15:0] chan_req = 16'h0000, seed = 16'h0059;
	logic [3:0] exec_len = 4'h1;
	csch_level_t [15:0] chan_level;
	logic exec_done, exec_busy, nop_active, trans_active;
	csch_grant_t grant;
	logic [2:0] slot_pos, pos_sh = 3'h0;
	logic [15:0] srl_q, sgl_q, srl_sh = 16'h0000, sgl_sh = 16'h0000;
	csch_level_t srv_lvl;
	logic exact = 1'h0;
	int err_count = 0, compares = 0, cyc = 0, gap = 0, exp_gap = 0;

	initial forever #50 clk_sys = ~clk_sys;

	csch_scheduler uut (.clk_sys(clk_sys), .rst(rst), .chan_req(chan_req), .chan_level(chan_level),
		.exec_done(exec_done), .grant(grant), .slot_pos(slot_pos), .service_request_latch(srl_q),
		.service_grant_latch(sgl_q), .exec_busy(exec_busy), .nop_active(nop_active),
		.trans_active(trans_active));
	csch_exec_model unit (.clk_sys(clk_sys), .rst(rst), .grant(grant), .exec_len(exec_len),
		.stray(stray), .exec_done(exec_done));

	// Shift register source of repeatable stimulus
	function automatic logic [15:0] rnd();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return seed;
	endfunction

	// Channels of one level
	function automatic logic [15:0] lmask(input csch_level_t [15:0] lv, input csch_level_t l);
		for (int i = 0; i < 16; i++) lmask[i] = (lv[i] == l);
	endfunction

	// Expected winner: slot level, then its passing order, lowest index first
	function automatic logic [6:0] pick(input logic [15:0] s, input logic [15:0] g,
		input csch_level_t [15:0] lv, input logic [2:0] p);
		csch_level_t o [3];
		o[0] = CSCH_SLOT_SEQ[p];
		o[1] = (o[0] == CSCH_LVL_HIGH) ? CSCH_LVL_MID : CSCH_LVL_HIGH;
		o[2] = (o[0] == CSCH_LVL_LOW) ? CSCH_LVL_MID : CSCH_LVL_LOW;
		for (int k = 0; k < 3; k++)
			for (int i = 0; i < 16; i++)
				if (s[i] && !g[i] && lv[i] == o[k]) return {1'h1, 4'(i), o[k]};
		return 7'h00;
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] a);
		compares++;
		if (e !== a) begin
			err_count++;
			$display("Error %s expected %0h seen %0h", nm, e, a);
		end
	endtask

	// One cycle of requests; state length random 1..15, stray end pulses rare
	task automatic step(input logic [15:0] rq, input logic sp);
		logic [15:0] v;
		v = rnd();
		@(posedge clk_sys);
		chan_req <= rq;
		exec_len <= (v[3:0] == 4'h0) ? 4'h1 : v[3:0];
		stray <= sp & v[4] & v[5] & v[6];
	endtask

	task automatic rand_run(input int n, input logic sp);
		logic [15:0] a, b;
		repeat (n) begin
			a = rnd();
			b = rnd();
			step(a & b, sp);
		end
	endtask

	// Software picks the levels
	task automatic set_levels(input logic all, input csch_level_t l);
		csch_level_t [15:0] t;
		logic [15:0] v;
		for (int i = 0; i < 16; i++) begin
			v = rnd();
			t[i] = all ? l : csch_level_t'(v[1:0]);
		end
		@(posedge clk_sys);
		chan_level <= t;
	endtask

	task automatic tally_and_finish();
		$display("Checks %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// Shadow scheduler: inputs seen before the edge, outputs checked just after
	always @(posedge clk_sys) begin : shadow
		logic [15:0] r, s0, gm, m;
		logic dn, bz, rs, cl;
		logic [6:0] pk;
		csch_level_t [15:0] lv;
		r = chan_req;
		s0 = srl_sh;
		lv = chan_level;
		rs = rst;
		bz = exec_busy;
		dn = exec_done & exec_busy;
		#1;
		gm = 16'h0000;
		gap++;
		if (rs) begin
			srl_sh = 16'h0000;
			sgl_sh = 16'h0000;
			pos_sh = 3'h0;
			exact = 1'h0;
		end else begin
			if (grant.start) begin
				pk = pick(s0, sgl_sh, lv, pos_sh);
				chk("grant", {25'h0, pk}, {25'h0, 1'h1, grant.chan, grant.level});
				chk("overlap", 32'h0, {31'h0, bz});
				if (exact) chk("gap", exp_gap, gap);
				gm = 16'h0001 << grant.chan;
				srv_lvl = grant.level;
			end
			// A grant that is due must not be missing
			if (exact && gap == exp_gap) chk("grant_due", 32'h1, {31'h0, grant.start});
			if (dn) begin
				m = lmask(lv, srv_lvl);
				cl = ((s0 & ~sgl_sh & m) == 16'h0000);
				if (cl) sgl_sh = sgl_sh & ~m;
				pos_sh = (pos_sh == CSCH_POS_LAST) ? CSCH_POS_FIRST : pos_sh + 3'h1;
				chk("nop", {31'h0, cl}, {31'h0, nop_active});
				chk("trans", {31'h0, ~cl}, {31'h0, trans_active});
				gap = 0;
				exp_gap = CSCH_TRANS_CLK + (cl ? CSCH_NOP_CLK : 0);
			end
			srl_sh = (s0 & ~gm) | r;
			sgl_sh = sgl_sh | gm;
			if (dn) exact = ((srl_sh & ~sgl_sh & ~lmask(lv, CSCH_LVL_OFF)) != 16'h0000);
			// New levels can empty the eligible set, so the exact gap no longer holds
			if (chan_level != lv) exact = 1'h0;
		end
		chk("slot_pos", {29'h0, pos_sh}, {29'h0, slot_pos});
		chk("req_latch", {16'h0, srl_sh}, {16'h0, srl_q});
		chk("grant_latch", {16'h0, sgl_sh}, {16'h0, sgl_q});
	end

	// Hang guard, well above the roughly 4000 cycles of the run
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 9000) begin
			err_count++;
			$display("Error timeout expected 0 seen %0d", cyc);
			tally_and_finish();
		end
	end

	initial begin
		for (int i = 0; i < 16; i++) chan_level[i] = CSCH_LVL_OFF;
		repeat (6) @(posedge clk_sys);
		rst <= 1'h0;
		// All high at once, channel 0 keeps asking
		set_levels(1'h1, CSCH_LVL_HIGH);
		step(16'hFFFF, 1'h0);
		repeat (400) step(16'h0001, 1'h0);
		$display("Test burst done");
		// One channel per level plus an off channel, all asking
		@(posedge clk_sys);
		for (int i = 3; i < 16; i++) chan_level[i] <= CSCH_LVL_OFF;
		chan_level[2] <= CSCH_LVL_LOW;
		chan_level[1] <= CSCH_LVL_MID;
		chan_level[0] <= CSCH_LVL_HIGH;
		repeat (600) step(16'h8007, 1'h0);
		$display("Test one_per_level done");
		// Single level only, so every other slot passes
		for (int j = 1; j < 4; j++) begin
			set_levels(1'h1, csch_level_t'(j));
			rand_run(300, 1'h0);
		end
		$display("Test passing done");
		set_levels(1'h0, CSCH_LVL_LOW);
		rand_run(1500, 1'h1);
		repeat (60) step(16'h0000, 1'h1);
		$display("Test random done");
		rand_run(50, 1'h0);
		@(posedge clk_sys);
		rst <= 1'h1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'h0;
		rand_run(100, 1'h0);
		repeat (300) step(16'h0000, 1'h0);
		$display("Test reset_mid done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
